// ===== bench/tb_top.sv
// Self-checking testbench of the dual cascadable timer
`timescale 1ns/10ps
module tb_top;
  import tmr_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic       wrStrobe = 1'b0;
  logic       rdStrobe = 1'b0;
  logic [7:0] rdData;
  logic       eventPinLo = 1'b1;
  logic       irqLo, irqHi, divLo, divHi, pulsePin;
  logic [7:0] rv;
  int         err_count = 0;
  int         compares = 0;
  int         cycles = 0;
  int         n;

  dual_timer i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .prescalerSourceSelect(1'b0), .lowSpeedPowerMode(1'b0),
    .slowTick(1'b0), .eventPinLo(eventPinLo), .eventPinHi(1'b1), .channelMatchInterruptLo(irqLo),
    .channelMatchInterruptHi(irqHi), .dividerOutputPinLo(divLo), .dividerOutputPinHi(divHi),
    .pulseGenOutputPin(pulsePin));

  always #2.5 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask : rd

  // Cycles until the chosen interrupt is next seen high
  task automatic wait_irq(input bit hi, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while (((hi ? irqHi : irqLo) !== 1'b1) && cnt < 3000);
  endtask : wait_irq

  task automatic t_reset;
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], rv);
      check("reset reg", {8'h00, rv}, 16'h0000);
    end
    rd(4'hF, rv);
    check("unmapped read", {8'h00, rv}, 16'h0000);
    check("pins idle", {13'h0, divLo, divHi, pulsePin}, 16'h0007);
    $display("test reset done");
  endtask : t_reset

  task automatic t_timer;
    wr(ADDR_CMP_LO, 8'h05);
    wr(ADDR_CTRL_LO, 8'h38);
    wait_irq(0, n);
    wait_irq(0, n);
    check("timer period", n[15:0], 16'd40);
    @(posedge clk);
    #1 check("irq width", {15'h0, irqLo}, 16'h0000);
    wr(ADDR_CTRL_LO, 8'h30);
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CTRL_LO, 8'h38);
    wait_irq(0, n);
    wait_irq(0, n);
    check("new compare period", n[15:0], 16'd24);
    wr(ADDR_CTRL_LO, 8'h30);
    rd(ADDR_CNT_LO, rv);
    check("stopped count", {8'h00, rv}, 16'h0000);
    $display("test timer done");
  endtask : t_timer

  task automatic t_event;
    int first;
    first = 0;
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CTRL_LO, 8'h78);
    for (int i = 1; i <= 5; i++) begin
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        eventPinLo <= (k >= 4);
        #1 if (irqLo === 1'b1 && first == 0) first = i;
      end
    end
    check("event match", first[15:0], 16'd3);
    wr(ADDR_CTRL_LO, 8'h70);
    $display("test event done");
  endtask : t_event

  task automatic t_divider;
    logic last;
    wr(ADDR_CMP_LO, 8'h04);
    wr(ADDR_CTRL_LO, 8'h39);
    for (int r = 0; r < 2; r++) begin
      last = divLo;
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (divLo === last && n < 100);
    end
    check("divider half period", n[15:0], 16'd32);
    wr(ADDR_CTRL_LO, 8'h31);
    $display("test divider done");
  endtask : t_divider

  task automatic t_chain;
    // Duty, warm-up and pulse modes are never selected here
    wr(ADDR_CTRL_LO, 8'h30);
    wr(ADDR_CMP_LO, 8'h02);
    wr(ADDR_CMP_HI, 8'h01);
    // Upper select points at a dead source, so counting proves the lower select drives the chain
    wr(ADDR_CTRL_HI, 8'h4C);
    rd(ADDR_CTRL_HI, rv);
    check("ctrl hi readback", {8'h00, rv}, 16'h004C);
    rd(ADDR_STATUS, rv);
    check("run status", {14'h0, rv[1:0]}, 16'h0003);
    wait_irq(1, n);
    wait_irq(1, n);
    check("chained period", n[15:0], 16'd2064);
    wr(ADDR_CTRL_HI, 8'h44);
    $display("test chain done");
  endtask : t_chain

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_timer();
    t_event();
    t_divider();
    t_chain();
    finish_test();
  end
endmodule : tb_top

// ===== src/dual_timer.sv
// Dual 8-bit timer/counter, chainable to 16 bits, with a plain register port
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module dual_timer
  import tmr_pkg::*;
#(
  parameter int PRE_BITS = PRE_WIDTH
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic [7:0]      rdData,
  input  wire logic       prescalerSourceSelect,
  input  wire logic       lowSpeedPowerMode,
  input  wire logic       slowTick,
  input  wire logic       eventPinLo,
  input  wire logic       eventPinHi,
  output logic            channelMatchInterruptLo,
  output logic            channelMatchInterruptHi,
  output logic            dividerOutputPinLo,
  output logic            dividerOutputPinHi,
  output logic            pulseGenOutputPin
);
  logic [7:0]          ctrlLo, ctrlHi, cmpLo, cmpHi, dutyLo, dutyHi;
  logic [PRE_BITS-1:0] prescaler;
  logic [PRE_BITS-1:0] prescalerPrev;
  logic [1:0]          pinSample;
  logic [7:0]          countLo, countHi;
  logic                ffLo, ffHi, matchLo, matchHi, wrapLo, wrapHi;

  wire logic [2:0] modeLo = ctrlLo[FLD_MODE_LSB +: 3];
  wire logic [2:0] modeHi = ctrlHi[FLD_MODE_LSB +: 3];
  wire logic       chained = modeHi[2];
  wire logic       runLo  = chained ? ctrlHi[FLD_RUN_BIT] : ctrlLo[FLD_RUN_BIT];
  wire logic       runHi  = ctrlHi[FLD_RUN_BIT];

  // Falling-edge detect on the divider taps and the event pins
  wire logic [PRE_BITS-1:0] tapFall = prescalerPrev & ~prescaler;
  wire logic [1:0]          pinFall = pinSample & ~{eventPinHi, eventPinLo};

  function automatic logic pick_tick(input logic [2:0] sel, input logic pinEdge);
    unique case (sel)
      3'd0:    pick_tick = prescalerSourceSelect || lowSpeedPowerMode ? slowTick : tapFall[10];
      3'd1:    pick_tick = tapFall[6];
      3'd2:    pick_tick = tapFall[4];
      3'd3:    pick_tick = tapFall[2];
      3'd4:    pick_tick = slowTick;
      3'd5:    pick_tick = tapFall[0];
      3'd6:    pick_tick = 1'b1;
      3'd7:    pick_tick = pinEdge;
    endcase
  endfunction : pick_tick

  // Chained modes take the source from the lower stage select only
  wire logic tickLo = pick_tick(ctrlLo[FLD_CLK_LSB +: 3], pinFall[0]);
  wire logic tickHiOwn = pick_tick(ctrlHi[FLD_CLK_LSB +: 3], pinFall[1]);
  wire logic tickHi = chained ? wrapLo : tickHiOwn;

  wire logic [15:0] count16 = {countHi, countLo};
  wire logic [15:0] next16  = count16 + 16'h0001;
  wire logic        hit16   = chained && runHi && tickLo && (next16 == {cmpHi, cmpLo});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescaler     <= '0;
      prescalerPrev <= '0;
      pinSample     <= 2'h0;
    end else begin
      prescaler     <= prescaler + {{(PRE_BITS-1){1'b0}}, 1'b1};
      prescalerPrev <= prescaler;
      pinSample     <= {eventPinHi, eventPinLo};
    end
  end

  // In chained mode the stages count freely and the 16-bit match clears both
  logic clr16;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr16 <= 1'b0;
    end else begin
      clr16 <= hit16;
    end
  end

  tmr_stage #(.WIDTH(8)) stageLo (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (runLo && !(chained && hit16)),
    .tick      (tickLo),
    .mode      (chained ? MODE_RSVD : modeLo),
    .ffInit    (ctrlLo[FLD_FF_BIT]),
    .cmpValue  (chained ? 8'h00 : cmpLo),
    .dutyValue (dutyLo),
    .count     (countLo),
    .outFf     (ffLo),
    .match     (matchLo),
    .wrap      (wrapLo)
  );

  tmr_stage #(.WIDTH(8)) stageHi (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (runHi && !(chained && hit16)),
    .tick      (tickHi),
    .mode      (chained ? MODE_RSVD : modeHi),
    .ffInit    (ctrlHi[FLD_FF_BIT]),
    .cmpValue  (chained ? 8'h00 : cmpHi),
    .dutyValue (dutyHi),
    .count     (countHi),
    .outFf     (ffHi),
    .match     (matchHi),
    .wrap      (wrapHi)
  );

  // Lower stage interrupt is silent when chained; the 16-bit match reports on the upper
  assign channelMatchInterruptLo = matchLo && !chained;
  assign channelMatchInterruptHi = chained ? hit16 : matchHi;
  assign dividerOutputPinLo      = ~ffLo;
  assign dividerOutputPinHi      = ~ffHi;
  assign pulseGenOutputPin       = ~ffHi;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlLo <= CTRL_RESET;
      ctrlHi <= CTRL_RESET;
      cmpLo  <= CMP_RESET;
      cmpHi  <= CMP_RESET;
      dutyLo <= DUTY_RESET;
      dutyHi <= DUTY_RESET;
    end else if (wrStrobe) begin
      unique case (addr)
        ADDR_CTRL_LO: ctrlLo <= wrData;
        ADDR_CTRL_HI: ctrlHi <= wrData;
        ADDR_CMP_LO:  cmpLo  <= wrData;
        ADDR_CMP_HI:  cmpHi  <= wrData;
        ADDR_DUTY_LO: dutyLo <= wrData;
        ADDR_DUTY_HI: dutyHi <= wrData;
        default: ;
      endcase
    end
  end

  wire logic [7:0] statusWord = {4'h0, ffHi, ffLo, runHi, runLo};
  wire logic [7:0] readMux =
      (addr == ADDR_CTRL_LO) ? ctrlLo :
      (addr == ADDR_CTRL_HI) ? ctrlHi :
      (addr == ADDR_CMP_LO)  ? cmpLo  :
      (addr == ADDR_CMP_HI)  ? cmpHi  :
      (addr == ADDR_DUTY_LO) ? dutyLo :
      (addr == ADDR_DUTY_HI) ? dutyHi :
      (addr == ADDR_CNT_LO)  ? countLo :
      (addr == ADDR_CNT_HI)  ? countHi :
      (addr == ADDR_STATUS)  ? statusWord : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      rdData <= readMux;
    end else begin
      rdData <= 8'h00;
    end
  end

  stop_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
    !runLo && !chained |=> countLo == 8'h00) else $error("stopped counter not zero");
  match_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
    channelMatchInterruptLo && modeLo == MODE_TIMER |=> countLo == 8'h00) else $error("no clear on match");
  match_value_a: assert property (@(posedge clk) disable iff (!arst_n)
    channelMatchInterruptLo && modeLo == MODE_TIMER |-> countLo + 8'h01 == cmpLo) else $error("match at wrong count");
  irq_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    channelMatchInterruptLo && cmpLo != 8'h01 && modeLo == MODE_TIMER |=> !channelMatchInterruptLo)
    else $error("interrupt longer than one cycle");
  count_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    runLo && !chained && tickLo && !matchLo |=> countLo == $past(countLo) + 8'h01) else $error("no increment");
  hold_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    runLo && !chained && !tickLo |=> countLo == $past(countLo)) else $error("counted without tick");
  chain_carry_a: assert property (@(posedge clk) disable iff (!arst_n)
    chained && runHi && wrapLo && !hit16 |=> countHi == $past(countHi) + 8'h01) else $error("no carry");
  chain_irq_a: assert property (@(posedge clk) disable iff (!arst_n)
    chained && hit16 |=> count16 == 16'h0000) else $error("16-bit match did not clear");
  restart_a: assert property (@(posedge clk) disable iff (!arst_n)
    channelMatchInterruptLo && modeLo == MODE_TIMER ##1 runLo && tickLo && cmpLo != 8'h01 |=> countLo == 8'h01)
    else $error("no restart after clear");
  // Chained clear lands one cycle after the 16-bit match
  chain_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    clr16 |-> count16 == 16'h0000) else $error("chained count not cleared");
  chain_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    chained && runHi && !tickLo |=> count16 == $past(count16)) else $error("chain moved without lower tick");
  lo_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    chained |-> !channelMatchInterruptLo) else $error("lower interrupt while chained");
  cmp_direct_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrStrobe && addr == ADDR_CMP_LO |=> cmpLo == $past(wrData)) else $error("compare not taken at once");
  div_toggle_a: assert property (@(posedge clk) disable iff (!arst_n)
    modeLo == MODE_DIV && !chained && matchLo |=> ffLo != $past(ffLo)) else $error("divider did not toggle");
  stop_ff_a: assert property (@(posedge clk) disable iff (!arst_n)
    !runLo && !chained |=> ffLo == $past(ctrlLo[FLD_FF_BIT])) else $error("stopped flip-flop not loaded");
  read_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    rdStrobe |=> rdData == $past(readMux)) else $error("read data wrong");
  read_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !rdStrobe |=> rdData == 8'h00) else $error("read data without strobe");
endmodule : dual_timer

// ===== src/tmr_pkg.sv
// Package with register map, field layout and modes of the dual cascadable timer
package tmr_pkg;
  localparam logic [3:0] ADDR_CTRL_LO  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_HI  = 4'h1;
  localparam logic [3:0] ADDR_CMP_LO   = 4'h2;
  localparam logic [3:0] ADDR_CMP_HI   = 4'h3;
  localparam logic [3:0] ADDR_DUTY_LO  = 4'h4;
  localparam logic [3:0] ADDR_DUTY_HI  = 4'h5;
  localparam logic [3:0] ADDR_CNT_LO   = 4'h6;
  localparam logic [3:0] ADDR_CNT_HI   = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam int         NUM_REGS      = 16;
  localparam int         FLD_MODE_LSB  = 0;
  localparam int         FLD_RUN_BIT   = 3;
  localparam int         FLD_CLK_LSB   = 4;
  localparam int         FLD_FF_BIT    = 7;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [7:0] DUTY_RESET    = 8'h00;
  localparam int         PRE_WIDTH     = 11;
  localparam int         PIN_CLK_SEL   = 7;
  typedef enum logic [2:0] {
    MODE_TIMER   = 3'b000,
    MODE_DIV     = 3'b001,
    MODE_PWM     = 3'b010,
    MODE_RSVD    = 3'b011,
    MODE_TIMER16 = 3'b100,
    MODE_WARMUP  = 3'b101,
    MODE_PWM16   = 3'b110,
    MODE_PULSE16 = 3'b111
  } mode_t;
endpackage : tmr_pkg

// ===== src/tmr_stage.sv
// One 8-bit counting stage with compare, duty compare and output flip-flop
`timescale 1ns/10ps
module tmr_stage
  import tmr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [2:0]       mode,
  input  wire logic             ffInit,
  input  wire logic [WIDTH-1:0] cmpValue,
  input  wire logic [WIDTH-1:0] dutyValue,
  output logic [WIDTH-1:0]      count,
  output logic                  outFf,
  output logic                  match,
  output logic                  wrap
);
  wire logic [WIDTH-1:0] nextUp  = count + {{(WIDTH-1){1'b0}}, 1'b1};
  wire logic             isPwm   = (mode == MODE_PWM);
  wire logic             isDiv   = (mode == MODE_DIV);
  wire logic             hitCmp  = run && tick && !isPwm && (nextUp == cmpValue);
  wire logic             hitDuty = run && tick && isPwm && (nextUp == dutyValue);
  wire logic             ovf     = run && tick && isPwm && (count == {WIDTH{1'b1}});

  assign match = hitCmp || ovf;
  assign wrap  = run && tick && (count == {WIDTH{1'b1}});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (hitCmp || ovf) begin
      count <= '0;
    end else if (tick) begin
      count <= nextUp;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outFf <= 1'b0;
    end else if (!run) begin
      outFf <= ffInit;
    end else if ((isDiv && hitCmp) || hitDuty || ovf) begin
      outFf <= ~outFf;
    end
  end
endmodule : tmr_stage
